// File: core/mupo_defines.svh
// object dictionary indices, field positions and preset values of the offset parameter bank
// assumes inclusion by bare name from the package and the design modules
`ifndef MUPO_DEFINES_SVH
`define MUPO_DEFINES_SVH

`define MUPO_IDX_JERK 16'h60a4
`define MUPO_IDX_POS_UNIT 16'h60a8
`define MUPO_IDX_VEL_UNIT 16'h60a9
`define MUPO_IDX_POS_OFS 16'h60b0
`define MUPO_IDX_VEL_OFS 16'h60b1
`define MUPO_IDX_TRQ_OFS 16'h60b2
`define MUPO_IDX_IP_REC 16'h60c1

`define MUPO_SUB_COUNT 8'h00
`define MUPO_SUB_FIRST 8'h01
`define MUPO_JERK_ENTRIES 8'h04
`define MUPO_IP_ENTRIES 8'h01

`define MUPO_JERK_RESET 32'h0000_03e8
`define MUPO_POS_UNIT_RESET 32'hff41_0000
`define MUPO_VEL_UNIT_RESET 32'h00b4_4700
`define MUPO_OFS_RESET 32'h0000_0000
`define MUPO_TRQ_RESET 16'h0000
`define MUPO_IP_RESET 32'h0000_0000

`define MUPO_TIME_LSB 8
`define MUPO_UNIT_LSB 16
`define MUPO_EXP_LSB 24
`define MUPO_POS_UNIT_MASK 32'hffff_0000
`define MUPO_VEL_UNIT_MASK 32'hffff_ff00

`define MUPO_MODE_IP 8'h07
`define MUPO_MODE_CSP 8'h08
`define MUPO_MODE_CSV 8'h09
`define MUPO_MODE_CST 8'h0a
`define MUPO_MODE_CLKDIR 8'hff

`endif

// File: core/mupo_pkg.sv
// types shared by the offset parameter bank modules
// assumes mupo_defines.svh is on the include path
package mupo_pkg;
  `include "mupo_defines.svh"

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } mupo_od_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } mupo_od_rsp_t;

  typedef logic [3:0][31:0] mupo_jerk_set_t;
endpackage

// File: core/mupo_jerk_bank.sv
// four jerk limit entries with their no-limit flags
// assumes one write strobe per cycle from the dictionary decoder on the same clock
`timescale 1ns/1ps
`include "mupo_defines.svh"
module mupo_jerk_bank
  import mupo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] wr_sel,
  input wire logic [31:0] wdata,
  output mupo_jerk_set_t jerk,
  output logic [3:0] unlimited
);
  // one storage element per entry, so no packed word has several writing processes
  logic [31:0] entry [4];
  logic entry_zero [4];

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_entry
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          entry[i] <= `MUPO_JERK_RESET;
        end else if (wr_sel[i]) begin
          entry[i] <= wdata;
        end
      end
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          entry_zero[i] <= 1'b0;
        end else if (wr_sel[i]) begin
          entry_zero[i] <= (wdata == 32'h0000_0000);
        end
      end
    end
  endgenerate

  assign jerk = {entry[3], entry[2], entry[1], entry[0]};
  assign unlimited = {entry_zero[3], entry_zero[2], entry_zero[1], entry_zero[0]};
endmodule

// File: core/mupo_setpoint_latch.sv
// interpolation set-point entry and its take-over at the synchronization event
// assumes sync_pin is asynchronous to ref_clk and its rising edge marks the event
`timescale 1ns/1ps
`include "mupo_defines.svh"
module mupo_setpoint_latch (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sync_pin,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] stored,
  output logic [31:0] target,
  output logic sync_tick
);
  logic sync_meta;
  logic sync_sync;
  logic sync_prev;
  wire sync_rise = sync_sync & ~sync_prev;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_prev <= 1'b0;
      sync_tick <= 1'b0;
    end else begin
      sync_meta <= sync_pin;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
      sync_tick <= sync_rise;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stored <= `MUPO_IP_RESET;
    end else if (wr_en) begin
      stored <= wdata;
    end
  end

  // take over only at sync; a write in the sync cycle goes straight through
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      target <= `MUPO_IP_RESET;
    end else if (sync_rise) begin
      target <= wr_en ? wdata : stored;
    end
  end
endmodule

// File: core/mupo_top.sv
// offset parameter bank: jerk limits, unit words, set-value offsets, ip set-point
// assumes dictionary requests and demand values come from logic on ref_clk;
// sync_pin comes from outside and is synchronised here
`timescale 1ns/1ps
`include "mupo_defines.svh"
module mupo_top
  import mupo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input mupo_od_req_t od_req,
  output mupo_od_rsp_t od_rsp,
  input wire logic sync_pin,
  input wire logic [7:0] op_mode,
  input wire logic [31:0] pos_demand,
  input wire logic [31:0] vel_demand,
  input wire logic [15:0] torque_demand,
  output logic [31:0] pos_cmd,
  output logic [31:0] vel_cmd,
  output logic [15:0] torque_cmd,
  output logic [31:0] ip_target,
  output logic ip_sync_tick,
  output mupo_jerk_set_t jerk,
  output logic [3:0] jerk_unlimited,
  output logic [31:0] pos_unit_word,
  output logic [31:0] vel_unit_word
);
  logic [31:0] pos_offset;
  logic [31:0] vel_offset;
  logic [15:0] trq_offset;
  logic [31:0] ip_stored;

  // index decode
  wire hit_jerk = (od_req.index == `MUPO_IDX_JERK);
  wire hit_pos_unit = (od_req.index == `MUPO_IDX_POS_UNIT);
  wire hit_vel_unit = (od_req.index == `MUPO_IDX_VEL_UNIT);
  wire hit_pos_ofs = (od_req.index == `MUPO_IDX_POS_OFS);
  wire hit_vel_ofs = (od_req.index == `MUPO_IDX_VEL_OFS);
  wire hit_trq_ofs = (od_req.index == `MUPO_IDX_TRQ_OFS);
  wire hit_ip = (od_req.index == `MUPO_IDX_IP_REC);

  // subindex decode
  wire sub_zero = (od_req.sub == `MUPO_SUB_COUNT);
  wire sub_jerk_ok = (od_req.sub >= `MUPO_SUB_FIRST) && (od_req.sub <= `MUPO_JERK_ENTRIES);
  wire sub_ip_ok = (od_req.sub >= `MUPO_SUB_FIRST) && (od_req.sub <= `MUPO_IP_ENTRIES);
  wire [1:0] jerk_slot = 2'(od_req.sub - `MUPO_SUB_FIRST);

  // a variable lives at subindex 0 only
  wire var_hit = sub_zero &
                 (hit_pos_unit | hit_vel_unit | hit_pos_ofs | hit_vel_ofs | hit_trq_ofs);
  wire jerk_entry_hit = hit_jerk & sub_jerk_ok;
  wire ip_entry_hit = hit_ip & sub_ip_ok;
  // entry counts are read-only
  wire count_hit = sub_zero & (hit_jerk | hit_ip);

  wire rw_hit = var_hit | jerk_entry_hit | ip_entry_hit;
  wire rd_hit = rw_hit | count_hit;

  // a write takes precedence when both strobes are raised together
  wire do_wr = od_req.wr;
  wire do_rd = od_req.rd & ~od_req.wr;
  wire wr_ok = do_wr & rw_hit;
  wire rd_ok = do_rd & rd_hit;
  wire any_req = do_wr | do_rd;
  wire req_err = (do_wr & ~rw_hit) | (do_rd & ~rd_hit);

  // write strobes
  wire wr_pos_unit = wr_ok & hit_pos_unit;
  wire wr_vel_unit = wr_ok & hit_vel_unit;
  wire wr_pos_ofs = wr_ok & hit_pos_ofs;
  wire wr_vel_ofs = wr_ok & hit_vel_ofs;
  wire wr_trq_ofs = wr_ok & hit_trq_ofs;
  wire wr_ip = wr_ok & hit_ip;
  wire wr_jerk = wr_ok & hit_jerk;
  wire [3:0] wr_jerk_sel;

  genvar j;
  generate
    for (j = 0; j < 4; j = j + 1) begin : g_jerk_wr
      assign wr_jerk_sel[j] = wr_jerk & (jerk_slot == 2'(j));
    end
  endgenerate

  // unit word fields; reserved positions are rebuilt as zero
  wire [7:0] wr_exponent = od_req.wdata[`MUPO_EXP_LSB +: 8];
  wire [7:0] wr_unit = od_req.wdata[`MUPO_UNIT_LSB +: 8];
  wire [7:0] wr_time = od_req.wdata[`MUPO_TIME_LSB +: 8];
  wire [31:0] next_pos_unit = {wr_exponent, wr_unit, 16'h0000};
  // velocity word keeps the time field too
  wire [31:0] next_vel_unit = {wr_exponent, wr_unit, wr_time, 8'h00};

  // read selection
  wire [31:0] rd_count = hit_jerk ? {24'h00_0000, `MUPO_JERK_ENTRIES} :
                                    {24'h00_0000, `MUPO_IP_ENTRIES};
  // object hits are one-hot, so an and-or tree replaces a priority chain
  wire [31:0] rd_pos_unit = {32{hit_pos_unit}} & pos_unit_word;
  wire [31:0] rd_vel_unit = {32{hit_vel_unit}} & vel_unit_word;
  wire [31:0] rd_pos_ofs = {32{hit_pos_ofs}} & pos_offset;
  wire [31:0] rd_vel_ofs = {32{hit_vel_ofs}} & vel_offset;
  // torque reads back zero-extended, not sign-extended
  wire [31:0] rd_trq_ofs = {32{hit_trq_ofs}} & {16'h0000, trq_offset};
  wire [31:0] rd_var = rd_pos_unit | rd_vel_unit | rd_pos_ofs | rd_vel_ofs | rd_trq_ofs;
  wire [31:0] rd_value = count_hit ? rd_count :
                         jerk_entry_hit ? jerk[jerk_slot] :
                         ip_entry_hit ? ip_stored :
                         var_hit ? rd_var :
                         32'h0000_0000;
  wire [31:0] next_rdata = rd_ok ? rd_value : 32'h0000_0000;
  wire next_ack = any_req;
  wire next_err = req_err;

  // mode decode
  wire mode_csp = (op_mode == `MUPO_MODE_CSP);
  wire mode_csv = (op_mode == `MUPO_MODE_CSV);
  wire mode_cst = (op_mode == `MUPO_MODE_CST);
  wire mode_clkdir = (op_mode == `MUPO_MODE_CLKDIR);

  wire pos_ofs_on = mode_csp;
  wire [31:0] pos_ofs_term = pos_ofs_on ? pos_offset : 32'h0000_0000;
  wire vel_ofs_on = mode_csp | mode_csv | mode_clkdir;
  wire [31:0] vel_ofs_term = vel_ofs_on ? vel_offset : 32'h0000_0000;
  wire trq_ofs_on = mode_csp | mode_cst | mode_clkdir;
  wire [15:0] trq_ofs_term = trq_ofs_on ? trq_offset : 16'h0000;

  // sums wrap in two's complement; the consumer is expected to clamp
  wire [31:0] next_pos_cmd = pos_demand + pos_ofs_term;
  wire [31:0] next_vel_cmd = vel_demand + vel_ofs_term;
  wire [15:0] next_torque_cmd = torque_demand + trq_ofs_term;

  // dictionary answer, one cycle after the request
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      od_rsp <= '0;
    end else begin
      od_rsp.ack <= next_ack;
      od_rsp.err <= next_err;
      od_rsp.rdata <= next_rdata;
    end
  end

  // position unit word, reserved half forced to zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_unit_word <= `MUPO_POS_UNIT_RESET;
    end else if (wr_pos_unit) begin
      pos_unit_word <= next_pos_unit;
    end
  end

  // velocity unit word, reserved byte forced to zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vel_unit_word <= `MUPO_VEL_UNIT_RESET;
    end else if (wr_vel_unit) begin
      vel_unit_word <= next_vel_unit;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_offset <= `MUPO_OFS_RESET;
    end else if (wr_pos_ofs) begin
      pos_offset <= od_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vel_offset <= `MUPO_OFS_RESET;
    end else if (wr_vel_ofs) begin
      vel_offset <= od_req.wdata;
    end
  end

  // torque offset takes the low half of the write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trq_offset <= `MUPO_TRQ_RESET;
    end else if (wr_trq_ofs) begin
      trq_offset <= od_req.wdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_cmd <= 32'h0000_0000;
    end else begin
      pos_cmd <= next_pos_cmd;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vel_cmd <= 32'h0000_0000;
    end else begin
      vel_cmd <= next_vel_cmd;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      torque_cmd <= 16'h0000;
    end else begin
      torque_cmd <= next_torque_cmd;
    end
  end

  mupo_jerk_bank u_jerk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_sel(wr_jerk_sel),
    .wdata(od_req.wdata),
    .jerk(jerk),
    .unlimited(jerk_unlimited)
  );

  mupo_setpoint_latch u_ip (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sync_pin(sync_pin),
    .wr_en(wr_ip),
    .wdata(od_req.wdata),
    .stored(ip_stored),
    .target(ip_target),
    .sync_tick(ip_sync_tick)
  );
endmodule

// File: tb/mupo_checker.sv
// port assertions for the offset parameter bank
// assumes a single ref_clk domain; bound into mupo_top
`timescale 1ns/1ps
module mupo_checker
  import mupo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input mupo_od_req_t od_req,
  input mupo_od_rsp_t od_rsp,
  input wire logic sync_pin,
  input wire logic [31:0] ip_target,
  input wire logic ip_sync_tick,
  input mupo_jerk_set_t jerk,
  input wire logic [3:0] jerk_unlimited,
  input wire logic [31:0] pos_unit_word,
  input wire logic [31:0] vel_unit_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire wr0 = od_req.wr && od_req.sub == 8'h00;
  wire jw = od_req.wr && od_req.index == 16'h60a4 && od_req.sub == 8'h01;
  sequence s_rise;
    !sync_pin ##1 sync_pin [*2];
  endsequence
  property p_ack; (od_req.wr || od_req.rd) |=> od_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_jwr; jw |=> jerk[0] == $past(od_req.wdata) && !od_rsp.err; endproperty
  a_jwr: assert property (p_jwr) else $error("jerk write lost");
  property p_unl; jerk_unlimited == {jerk[3] == 0, jerk[2] == 0, jerk[1] == 0, jerk[0] == 0};
  endproperty
  a_unl: assert property (p_unl) else $error("unlimited flag wrong");
  property p_pwr;
    wr0 && od_req.index == 16'h60a8 |=> pos_unit_word == ($past(od_req.wdata) & 32'hffff_0000);
  endproperty
  a_pwr: assert property (p_pwr) else $error("position unit write wrong");
  property p_vwr;
    wr0 && od_req.index == 16'h60a9 |=> vel_unit_word == ($past(od_req.wdata) & 32'hffff_ff00);
  endproperty
  a_vwr: assert property (p_vwr) else $error("velocity unit write wrong");
  property p_res; pos_unit_word[15:0] == 16'h0000 && vel_unit_word[7:0] == 8'h00; endproperty
  a_res: assert property (p_res) else $error("reserved unit bits set");
  property p_hold; $changed(ip_target) |-> ip_sync_tick; endproperty
  a_hold: assert property (p_hold) else $error("target moved without sync");
  property p_sync; s_rise |-> ##[1:3] ip_sync_tick; endproperty
  a_sync: assert property (p_sync) else $error("sync event not taken");
endmodule

bind mupo_top mupo_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .od_req(od_req),
  .od_rsp(od_rsp), .sync_pin(sync_pin), .ip_target(ip_target), .ip_sync_tick(ip_sync_tick),
  .jerk(jerk), .jerk_unlimited(jerk_unlimited), .pos_unit_word(pos_unit_word),
  .vel_unit_word(vel_unit_word));

// File: tb/mupo_master.sv
// fieldbus master model issuing dictionary requests
// assumes calls are made from the bench on ref_clk
`timescale 1ns/1ps
module mupo_master
  import mupo_pkg::*;
(
  input wire logic ref_clk,
  output mupo_od_req_t od_req,
  input mupo_od_rsp_t od_rsp
);
  initial od_req = '0;
  // payload is inverted on release so a stale value is never mistaken for a live one
  task automatic acc(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
      input logic [31:0] d);
    @(posedge ref_clk);
    od_req <= '{wr, !wr, ix, sb, d};
    @(posedge ref_clk);
    od_req <= '{1'b0, 1'b0, ~ix, ~sb, ~d};
  endtask
endmodule

// File: tb/motion_unit_offset_params_bench.sv
// self-checking bench for the offset parameter bank
// assumes mupo_master as far side and mupo_checker bound into mupo_top
`timescale 1ns/1ps
module motion_unit_offset_params_bench;
  import mupo_pkg::*;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic sync_pin = 0;
  logic [7:0] op_mode = 0;
  logic [31:0] pos_demand = 0;
  logic [31:0] vel_demand = 0;
  logic [15:0] torque_demand = 0;
  mupo_od_req_t od_req;
  mupo_od_rsp_t od_rsp;
  logic [31:0] pos_cmd, vel_cmd, ip_target, pos_unit_word, vel_unit_word, v, w;
  logic [15:0] torque_cmd;
  logic ip_sync_tick;
  mupo_jerk_set_t jerk;
  logic [3:0] jerk_unlimited;
  logic [32:0] exp_q[$];
  logic [7:0] modes[6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'hff, 8'h00};
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h52a6_8231;
  mupo_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .od_req(od_req), .od_rsp(od_rsp),
    .sync_pin(sync_pin), .op_mode(op_mode), .pos_demand(pos_demand), .vel_demand(vel_demand),
    .torque_demand(torque_demand), .pos_cmd(pos_cmd), .vel_cmd(vel_cmd),
    .torque_cmd(torque_cmd), .ip_target(ip_target), .ip_sync_tick(ip_sync_tick), .jerk(jerk),
    .jerk_unlimited(jerk_unlimited), .pos_unit_word(pos_unit_word),
    .vel_unit_word(vel_unit_word));
  mupo_master mst (.ref_clk(ref_clk), .od_req(od_req), .od_rsp(od_rsp));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_rsp(input logic [32:0] e);
    cmp("rsp", e, {od_rsp.err, od_rsp.rdata});
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // expected answer is queued before the request goes out
  task automatic acc(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
      input logic [31:0] d, input logic er, input logic [31:0] ex);
    exp_q.push_back({er, ex});
    mst.acc(wr, ix, sb, d);
  endtask
  always @(posedge ref_clk) begin
    if (!sys_rst && od_rsp.ack === 1'b1) begin
      cmp_rsp(exp_q.size() ? exp_q.pop_front() : 'x);
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc(0, 16'h60a4, 0, 0, 0, 32'h4);
    for (int i = 1; i <= 4; i++) acc(0, 16'h60a4, 8'(i), 0, 0, 32'h3e8);
    acc(0, 16'h60a8, 0, 0, 0, 32'hff41_0000);
    acc(0, 16'h60a9, 0, 0, 0, 32'h00b4_4700);
    for (int i = 0; i < 3; i++) acc(0, 16'(16'h60b0 + i), 0, 0, 0, 0);
    acc(0, 16'h60c1, 1, 0, 0, 0);
    for (int i = 1; i <= 4; i++) begin
      v = (i == 4) ? 32'h0 : $random(seed);
      acc(1, 16'h60a4, 8'(i), v, 0, 0);
      acc(0, 16'h60a4, 8'(i), 0, 0, v);
      cmp("jerk", v, jerk[i - 1]);
    end
    cmp("unlimited", 4'b1000, jerk_unlimited);
    v = $random(seed);
    acc(1, 16'h60a8, 0, v, 0, 0);
    acc(0, 16'h60a8, 0, 0, 0, v & 32'hffff_0000);
    acc(1, 16'h60a9, 0, v, 0, 0);
    acc(0, 16'h60a9, 0, 0, 0, v & 32'hffff_ff00);
    acc(1, 16'h60b2, 0, v, 0, 0);
    acc(0, 16'h60b2, 0, 0, 0, {16'h0000, v[15:0]});
    // refused accesses change nothing
    acc(1, 16'h60a4, 0, v, 1, 0);
    acc(0, 16'h60a4, 5, 0, 1, 0);
    acc(1, 16'h60c1, 2, v, 1, 0);
    acc(0, 16'h60b0, 1, 0, 1, 0);
    acc(0, 16'h60a4, 0, 0, 0, 32'h4);
    w = $random(seed);
    acc(1, 16'h60b0, 0, w, 0, 0);
    acc(1, 16'h60b1, 0, ~w, 0, 0);
    foreach (modes[k]) begin
      op_mode <= modes[k];
      pos_demand <= $random(seed);
      vel_demand <= $random(seed);
      torque_demand <= 16'($random(seed));
      repeat (2) @(posedge ref_clk);
      cmp("pos_cmd", 32'(pos_demand + (op_mode == 8'h08 ? w : 0)), pos_cmd);
      cmp("vel_cmd", 32'(vel_demand + (op_mode inside {8'h08, 8'h09, 8'hff} ? ~w : 0)),
        vel_cmd);
      cmp("torque_cmd", 16'(torque_demand + (op_mode inside {8'h08, 8'h0a, 8'hff} ? v[15:0] :
        16'h0)), torque_cmd);
    end
    w = $random(seed);
    acc(1, 16'h60c1, 1, w, 0, 0);
    acc(0, 16'h60c1, 1, 0, 0, w);
    cmp("ip_target", 0, ip_target);
    sync_pin <= 1'b1;
    for (int i = 0; i < 8 && ip_sync_tick !== 1'b1; i++) @(posedge ref_clk);
    cmp("ip_sync_tick", 1, ip_sync_tick);
    cmp("ip_target", w, ip_target);
    sync_pin <= 1'b0;
    acc(1, 16'h60c1, 1, ~w, 0, 0);
    repeat (4) @(posedge ref_clk);
    cmp("ip_target", w, ip_target);
    // a second reset brings back the presets
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cmp("unlimited", 0, jerk_unlimited);
    cmp("ip_target", 0, ip_target);
    acc(0, 16'h60a4, 8'h04, 0, 0, 32'h3e8);
    acc(0, 16'h60b0, 0, 0, 0, 0);
    repeat (2) @(posedge ref_clk);
    cmp("pending", 0, exp_q.size());
    finish_test;
  end
endmodule
